// File: src/seq_defs.svh
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
// Clock period in ns
`define CLK_PERIOD_NS      100
// Rail step spacing, us (within 0..10)
`define RAIL_STEP_US       5
`define RAIL_STEP_CYC      ((`RAIL_STEP_US * 1000) / `CLK_PERIOD_NS)
// Hard reset low time, ms
`define HARD_RESET_MS      1
`define HARD_RESET_CYC     ((`HARD_RESET_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Internal initialisation, in external clock cycles
`define INIT_EXT_CYC       160000
// PLL lock wait, ms
`define PLL_LOCK_MS        1
`define PLL_LOCK_CYC       ((`PLL_LOCK_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Off time between power cycles, ms
`define OFF_TIME_MS        100
`define OFF_TIME_CYC       ((`OFF_TIME_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Default frame time in cycles (about 20 ms)
`define FRAME_CYC          200000
// Rail bit positions in the rail vector
`define RAIL_PLL           0
`define RAIL_ANALOG        1
`define RAIL_IO            2
`define RAIL_CORE          3
`define RAIL_SERIAL        4
`define RAIL_COUNT         5
`endif

// File: src/seq_pkg.sv
package seq_pkg;
    // Sequencer phases
    typedef enum logic [3:0] {
        ST_OFF,
        ST_RAILS_UP,
        ST_RESET,
        ST_INIT,
        ST_CONFIG,
        ST_PLL_WAIT,
        ST_STREAM_ON,
        ST_STREAMING,
        ST_STREAM_OFF,
        ST_DRAIN,
        ST_RAILS_DOWN,
        ST_COOL
    } seq_state_e;
    // Width of the timer
    typedef logic [31:0] count_t;
endpackage

// File: src/timer_if.sv
// Load-and-run timer shared between sequencer and its counter
interface timer_if;
    logic          load;   // Start a new count
    seq_pkg::count_t value; // Cycles to wait
    logic          done;   // Count expired (level)
    modport master (output load, output value, input done);
    modport slave  (input load, input value, output done);
endinterface

// File: src/seq_timer.sv
`include "seq_defs.svh"
module seq_timer (
    input  wire logic clk_i,  // System clock
    input  wire logic rst_i,  // Async reset, high
    timer_if.slave    tmr     // Timer control
);
    import seq_pkg::*;
    count_t cnt_q;  // Remaining cycles
    count_t cnt_d;
    logic   done_q; // Expired flag
    logic   done_d;

    // Next count: load wins, else count down to zero
    always_comb begin
        cnt_d  = cnt_q;
        done_d = done_q;
        if (tmr.load) begin
            cnt_d  = tmr.value;
            done_d = 1'b0;
        end else if (cnt_q > 32'h1) begin
            cnt_d = cnt_q - 32'h1;
        end else begin
            cnt_d  = 32'h0;
            done_d = 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= 32'h0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign tmr.done = done_q;
endmodule

// File: src/sensor_power_reset_sequencer.sv
// Overview of operation
// RULE_01: Raise rails PLL, analog, IO, core, serial.
// RULE_02: PLL rail never rises after others.
// RULE_03: Start external clock after last rail.
// RULE_04: Hold reset low at least 1 ms.
// RULE_05: Wait 160000 external clocks after release.
// RULE_06: Program settings during software standby.
// RULE_07: Wait 1 ms PLL lock before streaming.
// RULE_08: Final step writes streaming bit one.
// RULE_09: Power-down starts by clearing streaming bit.
// RULE_10: Device stops after current row/frame.
// RULE_11: Drop rails serial, core, IO, analog, PLL.
// RULE_12: Stay off at least 100 ms.
// RULE_13: Wait one frame before removing supplies.
`include "seq_defs.svh"
module sensor_power_reset_sequencer #(
    parameter int unsigned RAIL_STEP_CYC  = `RAIL_STEP_CYC,  // Rail spacing
    parameter int unsigned HARD_RESET_CYC = `HARD_RESET_CYC, // Reset low
    parameter int unsigned INIT_EXT_CYC   = `INIT_EXT_CYC,   // Init clocks
    parameter int unsigned PLL_LOCK_CYC   = `PLL_LOCK_CYC,   // PLL lock
    parameter int unsigned OFF_TIME_CYC   = `OFF_TIME_CYC,   // Off time
    parameter int unsigned FRAME_CYC      = `FRAME_CYC       // Frame time
) (
    input  wire logic        clk_i,           // System clock, 10 MHz
    input  wire logic        rst_i,           // Async reset, high
    input  wire logic        power_up_i,      // Request power-up (level)
    input  wire logic        power_down_i,    // Request power-down (level)
    input  wire logic        config_done_i,   // Settings programmed (pulse)
    input  wire logic        wr_done_i,       // Register write finished
    input  wire logic        ext_clk_fb_i,    // External clock, async
    output logic [`RAIL_COUNT-1:0] rail_en_o, // Rail enables
    output logic             ext_clk_en_o,    // External clock enable
    output logic             reset_n_o,       // Sensor hard reset, low
    output logic             config_req_o,    // Program PLL/image now
    output logic             wr_req_o,        // Write streaming bit
    output logic             wr_stream_o,     // Value of streaming bit
    output logic             ready_o,         // Streaming active
    output seq_pkg::seq_state_e state_o       // Current phase
);
    import seq_pkg::*;

    seq_state_e state_q, state_d;         // Phase
    logic [`RAIL_COUNT-1:0] rail_q, rail_d; // Rail enables
    logic [2:0] step_q, step_d;           // Rail step index
    logic       clk_en_q, clk_en_d;       // Clock enable
    logic       rstn_q, rstn_d;           // Reset pin
    logic       cfg_q, cfg_d;             // Config request
    logic       wr_q, wr_d;               // Write request
    logic       wval_q, wval_d;           // Write value
    logic       ready_q, ready_d;         // Streaming phase flag
    logic [2:0] ext_sync_q;               // Clock sync + edge history
    count_t     ext_cnt_q, ext_cnt_d;     // External clock edges
    timer_if    tmr ();                   // Shared timer

    seq_timer u_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tmr   (tmr)
    );

    // Rail index for step n going up; down order is the reverse
    function automatic logic [2:0] up_rail(input logic [2:0] n);
        up_rail = n; // Up order equals bit order
    endfunction

    // Synchroniser for the external clock; stage 0 feeds only stage 1
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_clk_fb_i};
        end
    end
    wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2]; // Rising edge seen

    // Phase and output next values
    always_comb begin
        state_d   = state_q;
        rail_d    = rail_q;
        step_d    = step_q;
        clk_en_d  = clk_en_q;
        rstn_d    = rstn_q;
        cfg_d     = 1'b0;
        wr_d      = 1'b0;
        wval_d    = wval_q;
        ext_cnt_d = ext_cnt_q;
        tmr.load  = 1'b0;
        tmr.value = 32'h0;
        unique case (state_q)
            ST_OFF: begin
                rstn_d = 1'b0; // Reset held low while unpowered
                if (power_up_i) begin
                    rail_d[`RAIL_PLL] = 1'b1; // PLL first, see RULE_02
                    step_d    = 3'h1;
                    tmr.load  = 1'b1;
                    tmr.value = RAIL_STEP_CYC;
                    state_d   = ST_RAILS_UP;
                end
            end
            ST_RAILS_UP: begin
                if (tmr.done) begin
                    if (step_q < 3'(`RAIL_COUNT)) begin
                        rail_d[up_rail(step_q)] = 1'b1; // see RULE_01
                        step_d    = step_q + 3'h1;
                        tmr.load  = 1'b1;
                        tmr.value = RAIL_STEP_CYC;
                    end else begin
                        clk_en_d  = 1'b1; // Rails stable, see RULE_03
                        tmr.load  = 1'b1;
                        tmr.value = HARD_RESET_CYC;
                        state_d   = ST_RESET;
                    end
                end
            end
            ST_RESET: begin
                if (tmr.done) begin
                    rstn_d    = 1'b1; // Held 1 ms, see RULE_04
                    ext_cnt_d = 32'h0;
                    state_d   = ST_INIT;
                end
            end
            ST_INIT: begin
                if (ext_rise) begin
                    ext_cnt_d = ext_cnt_q + 32'h1;
                end
                // Edges synchronised just after release may have risen
                // before it; two spare edges keep the count on the safe side
                if (ext_cnt_q >= INIT_EXT_CYC + 32'h2) begin
                    cfg_d   = 1'b1; // Standby reached, see RULE_05
                    state_d = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                cfg_d = 1'b1; // Hold until programmed, see RULE_06
                if (config_done_i) begin
                    cfg_d     = 1'b0;
                    tmr.load  = 1'b1;
                    tmr.value = PLL_LOCK_CYC;
                    state_d   = ST_PLL_WAIT;
                end
            end
            ST_PLL_WAIT: begin
                if (tmr.done) begin
                    wr_d    = 1'b1; // Lock time over, see RULE_07
                    wval_d  = 1'b1; // Streaming on, see RULE_08
                    state_d = ST_STREAM_ON;
                end
            end
            ST_STREAM_ON: begin
                wr_d = ~wr_done_i;
                if (wr_done_i) begin
                    state_d = ST_STREAMING;
                end
            end
            ST_STREAMING: begin
                if (power_down_i) begin
                    wr_d    = 1'b1;
                    wval_d  = 1'b0; // Stop first, see RULE_09
                    state_d = ST_STREAM_OFF;
                end
            end
            ST_STREAM_OFF: begin
                wr_d = ~wr_done_i;
                if (wr_done_i) begin
                    tmr.load  = 1'b1;
                    tmr.value = FRAME_CYC; // see RULE_13
                    state_d   = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // Covers row or frame completion, see RULE_10
                if (tmr.done) begin
                    rail_d[`RAIL_SERIAL] = 1'b0; // see RULE_11
                    step_d    = 3'(`RAIL_SERIAL);
                    tmr.load  = 1'b1;
                    tmr.value = RAIL_STEP_CYC;
                    state_d   = ST_RAILS_DOWN;
                end
            end
            ST_RAILS_DOWN: begin
                if (tmr.done) begin
                    if (step_q > 3'h0) begin
                        rail_d[up_rail(step_q - 3'h1)] = 1'b0; // see RULE_11
                        step_d    = step_q - 3'h1;
                        tmr.load  = 1'b1;
                        tmr.value = RAIL_STEP_CYC;
                    end else begin
                        clk_en_d  = 1'b0;
                        rstn_d    = 1'b0;
                        tmr.load  = 1'b1;
                        tmr.value = OFF_TIME_CYC; // see RULE_12
                        state_d   = ST_COOL;
                    end
                end
            end
            ST_COOL: begin
                if (tmr.done && !power_up_i) begin
                    state_d = ST_OFF;
                end else if (tmr.done) begin
                    state_d = ST_OFF; // Relaunch from off
                end
            end
        endcase
        // Ready follows the next phase so the output stays a flop
        ready_d = (state_d == ST_STREAMING);
    end

    // Register stage; outputs drive straight from these flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q   <= ST_OFF;
            rail_q    <= '0;
            step_q    <= 3'h0;
            clk_en_q  <= 1'b0;
            rstn_q    <= 1'b0;
            cfg_q     <= 1'b0;
            wr_q      <= 1'b0;
            wval_q    <= 1'b0;
            ext_cnt_q <= 32'h0;
            ready_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            rail_q    <= rail_d;
            step_q    <= step_d;
            clk_en_q  <= clk_en_d;
            rstn_q    <= rstn_d;
            cfg_q     <= cfg_d;
            wr_q      <= wr_d;
            wval_q    <= wval_d;
            ext_cnt_q <= ext_cnt_d;
            ready_q   <= ready_d;
        end
    end

    assign rail_en_o    = rail_q;
    assign ext_clk_en_o = clk_en_q;
    assign reset_n_o    = rstn_q;
    assign config_req_o = cfg_q;
    assign wr_req_o     = wr_q;
    assign wr_stream_o  = wval_q;
    assign ready_o      = ready_q;
    assign state_o      = state_q;

    // PLL rail is up whenever any other rail is up
    a_pll_first: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_02
        (|rail_q) |-> rail_q[`RAIL_PLL])
        else $error("rail on without PLL rail");
    // Clock only with all rails up, or while rails drop
    a_clk_rails: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_03
        clk_en_q |-> (&rail_q) || state_q == ST_RAILS_DOWN)
        else $error("clock enabled without rails");
    // Reset release only after reset state
    a_reset_rel: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_04
        $rose(rstn_q) |-> $past(state_q) == ST_RESET)
        else $error("reset released early");
    // Config request only after init count
    a_init_wait: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_05
        $rose(cfg_q) |-> ext_cnt_q >= INIT_EXT_CYC)
        else $error("config before init done");
    // Streaming write follows PLL wait
    a_stream_on: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_07
        $rose(wval_q) |-> $past(state_q) == ST_PLL_WAIT)
        else $error("stream on without PLL wait");
    // Power-down write clears the bit
    a_stream_off: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_09
        state_q == ST_STREAM_OFF |-> !wval_q)
        else $error("stop write has bit set");
    // Rails drop only after drain
    a_rails_down: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_13
        $fell(rail_q[`RAIL_SERIAL]) |-> $past(state_q) == ST_DRAIN)
        else $error("rail removed before drain");
    // Off time precedes next power-up
    a_off_time: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_12
        $rose(rail_q[`RAIL_PLL]) |-> $past(state_q) == ST_OFF)
        else $error("power-up without off time");
endmodule

// File: test/sensor_model.sv
module sensor_model #(
    parameter int HOLD_MIN   = 5,  // Reset low cycles required
    parameter int INIT_EDGES = 4,  // Clock edges of initialisation
    parameter int FRAME_LEN  = 8,  // Frame length in cycles
    parameter int OFF_MIN    = 10  // Off cycles before power-up
) (
    input  wire logic       clk_i,        // System clock
    input  wire logic [4:0] rail_en_i,    // Rail enables
    input  wire logic       ext_clk_en_i, // Clock enable
    input  wire logic       reset_n_i,    // Hard reset, low
    input  wire logic       wr_req_i,     // Control write request
    input  wire logic       wr_stream_i,  // Streaming bit value
    input  wire logic [3:0] wr_lat_i,     // Write answer delay
    output logic            ext_clk_o,    // Clock seen at device
    output logic            wr_done_o,    // Write finished
    output logic            streaming_o,  // Device streaming
    output logic [7:0]      faults_o      // Breaches seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] rail_q;  // Rails one cycle ago
    logic       en_q;    // Clock enable one cycle ago
    logic       rst_n_q; // Reset one cycle ago
    logic       stop_q;  // Stop requested, frame running out
    logic       busy_q;  // Write already answered
    int         hold_n;  // Reset low cycles with rails up
    int         off_n;   // Cycles with all rails off
    int         frame_n; // Position in frame
    int         lat_n;   // Write answer delay count
    int         init_n;  // Initialisation clock edges
    int         f;       // Breaches this cycle
    initial begin
        {rail_q, en_q, rst_n_q, stop_q, busy_q} = '0;
        {ext_clk_o, wr_done_o, streaming_o, faults_o} = '0;
        {hold_n, frame_n, lat_n, init_n} = '0;
        off_n = 1000;
    end
    // Clock stands low while disabled; period is three clk_i cycles, its edges fall on clk_i edges
    always #150 ext_clk_o = ext_clk_en_i ? ~ext_clk_o : 1'b0;
    // Initialisation counts input clocks after reset release
    always @(posedge ext_clk_o or negedge reset_n_i) begin
        if (!reset_n_i) init_n <= 0;
        else if (init_n < INIT_EDGES) init_n <= init_n + 1;
    end
    // Supply, reset and write checks, plus the control bit
    always @(posedge clk_i) begin
        f = 0;
        if (|(rail_en_i & ~rail_q & ~{rail_en_i[3:0], 1'b1})) f++;
        if (|(rail_q & ~rail_en_i & {1'b0, rail_en_i[4:1]})) f++;
        if (|(rail_q & ~rail_en_i) && streaming_o) f++;
        if (ext_clk_en_i && !en_q && rail_en_i != 5'h1F) f++;
        if (reset_n_i && !rst_n_q && hold_n < HOLD_MIN) f++;
        if (wr_req_i && init_n < INIT_EDGES) f++;
        if (rail_en_i[0] && !rail_q[0] && off_n < OFF_MIN) f++;
        faults_o <= faults_o + f[7:0];
        hold_n <= (rail_en_i == 5'h1F && !reset_n_i) ? hold_n + 1 : 0;
        off_n <= (rail_en_i == 5'h00) ? off_n + 1 : 0;
        {rail_q, en_q, rst_n_q} <= {rail_en_i, ext_clk_en_i, reset_n_i};
        wr_done_o <= 1'b0;
        frame_n <= (frame_n == FRAME_LEN - 1) ? 0 : frame_n + 1;
        // Stop only at the end of the frame in progress
        if (stop_q && frame_n == FRAME_LEN - 1) begin
            streaming_o <= 1'b0;
            stop_q <= 1'b0;
        end
        if (!wr_req_i) begin
            busy_q <= 1'b0;
            lat_n <= 0;
        end else if (!busy_q && lat_n >= int'(wr_lat_i)) begin
            wr_done_o <= 1'b1;
            busy_q <= 1'b1;
            if (wr_stream_i) streaming_o <= 1'b1;
            else stop_q <= 1'b1;
        end else if (!busy_q) begin
            lat_n <= lat_n + 1;
        end
    end
endmodule

// File: test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import seq_pkg::*;
    logic        clk_i, rst_i, power_up_i, power_down_i; // Bench drives
    logic        config_done_i, wr_done_i, ext_clk_fb_i; // Inputs
    logic [4:0]  rail_en_o;                    // Rail enables
    logic        ext_clk_en_o, reset_n_o;      // Clock, reset
    logic        config_req_o, wr_req_o;       // Host requests
    logic        wr_stream_o, ready_o;         // Write value, ready
    seq_state_e  state_o;                      // Phase
    logic        streaming;                    // Device streaming
    logic [7:0]  faults;                       // Device breaches
    logic [3:0]  wr_lat;                       // Write answer delay
    int          failures, n_compared;         // Counters
    sensor_power_reset_sequencer #(.HARD_RESET_CYC(5),
        .INIT_EXT_CYC(4), .PLL_LOCK_CYC(5), .OFF_TIME_CYC(10),
        .FRAME_CYC(10)) u_sensor_power_reset_sequencer (.clk_i(clk_i),
        .rst_i(rst_i), .power_up_i(power_up_i), .power_down_i(power_down_i),
        .config_done_i(config_done_i), .wr_done_i(wr_done_i),
        .ext_clk_fb_i(ext_clk_fb_i), .rail_en_o(rail_en_o),
        .ext_clk_en_o(ext_clk_en_o), .reset_n_o(reset_n_o),
        .config_req_o(config_req_o), .wr_req_o(wr_req_o),
        .wr_stream_o(wr_stream_o), .ready_o(ready_o), .state_o(state_o));
    sensor_model u_sensor_model (.clk_i(clk_i), .rail_en_i(rail_en_o),
        .ext_clk_en_i(ext_clk_en_o), .reset_n_i(reset_n_o),
        .wr_req_i(wr_req_o), .wr_stream_i(wr_stream_o), .wr_lat_i(wr_lat),
        .ext_clk_o(ext_clk_fb_i), .wr_done_o(wr_done_i),
        .streaming_o(streaming), .faults_o(faults));
    // 10 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Prints the counts and the verdict, then stops
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One comparison of a design value
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Bounded wait for a phase; a hang ends the run
    task automatic wait_state(seq_state_e s);
        for (int i = 0; i < 2000 && state_o !== s; i++) @(negedge clk_i);
        if (state_o !== s) begin
            failures++;
            complete_run();
        end
    endtask
    // Bounded wait for a write request, returns cycles taken
    task automatic wait_wr(output int n);
        for (n = 0; n < 200 && wr_req_o !== 1'b1; n++) @(negedge clk_i);
        if (wr_req_o !== 1'b1) begin
            failures++;
            complete_run();
        end
    endtask
    // Full power-up, with a refused power-down and slow software
    task automatic power_up_scn(input logic [3:0] lat);
        int n;
        wr_lat = lat;
        power_up_i = 1'b1;
        power_down_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk("first rail", 32'h01, 32'(rail_en_o));
        power_up_i = 1'b0;
        wait_state(ST_CONFIG);
        chk("config req", 32'h1, 32'(config_req_o));
        // Software is slow; nothing may start meanwhile
        repeat (20) @(negedge clk_i);
        chk("no early write", 32'h0, 32'(wr_req_o));
        chk("phase held", 32'(ST_CONFIG), 32'(state_o));
        power_down_i = 1'b0;
        config_done_i = 1'b1;
        @(negedge clk_i);
        config_done_i = 1'b0;
        wait_wr(n);
        chk("lock wait", 32'h1, 32'(n >= 5));
        chk("stream bit", 32'h1, 32'(wr_stream_o));
        wait_state(ST_STREAMING);
        chk("ready", 32'h1, 32'(ready_o));
        chk("rails", 32'h1F, 32'(rail_en_o));
        chk("clock", 32'h1, 32'(ext_clk_en_o));
        chk("reset", 32'h1, 32'(reset_n_o));
        chk("device on", 32'h1, 32'(streaming));
    endtask
    // Power-down from streaming with a given write delay
    task automatic power_down_scn(input logic [3:0] lat);
        int n;
        wr_lat = lat;
        power_down_i = 1'b1;
        wait_wr(n);
        chk("stop bit", 32'h0, 32'(wr_stream_o));
        power_down_i = 1'b0;
        wait_state(ST_OFF);
        chk("rails off", 32'h00, 32'(rail_en_o));
        chk("clock off", 32'h0, 32'(ext_clk_en_o));
        chk("reset low", 32'h0, 32'(reset_n_o));
        chk("not ready", 32'h0, 32'(ready_o));
        chk("device off", 32'h0, 32'(streaming));
    endtask
    // Reset in mid-stream returns everything to off
    task automatic reset_scn();
        rst_i = 1'b1;
        @(negedge clk_i);
        chk("reset rails", 32'h00, 32'(rail_en_o));
        chk("reset pin", 32'h0, 32'(reset_n_o));
        chk("reset phase", 32'(ST_OFF), 32'(state_o));
        rst_i = 1'b0;
    endtask
    // Main sequence
    initial begin
        {failures, n_compared} = '0;
        {rst_i, power_up_i, power_down_i, config_done_i} = 4'h8;
        wr_lat = 4'h0;
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        power_up_scn(4'h0);
        power_down_scn(4'h6);
        power_up_scn(4'h3);
        power_down_scn(4'h0);
        power_up_scn(4'h1);
        chk("device faults", 32'h0, 32'(faults));
        reset_scn();
        complete_run();
    end
endmodule
